// ---- common/cp_cond_pkg.sv ----
// Purpose: shared constants and types for the coprocessor conditional sequencer
// Assumes: 16-bit instruction words, 32-bit data registers and addresses
// Notes:   register indices are word indices on the plain register port
//
// Functional notes
// - loop-branch opcode: bits 8..3 equal 001001
// - conditional opcodes have 1111 on top, bits 11..9 select
// - low three opcode bits pick loop counter
// - loop-branch writes selector word to condition register
// - extension word count set by coprocessor design
// - loop displacement is sign-extended 16-bit value
// - serve requests, reread response until condition result
// - true result falls through, counter untouched
// - false result decrements counter low half only
// - counter minus one falls through, else branch
// - target is scan pointer at displacement plus displacement
// - trap opcode: bits 8..3 equal 001111
// - trap opmode 010 one, 011 two, 100 none
// - trap writes selector word to condition register
// - trap operand words skipped without interpretation
// - true trap result raises exception, false continues
package cp_cond_pkg;

    localparam logic [3:0]  FLINE_CODE  = 4'hf;    // top nibble of every conditional op
    localparam logic [5:0]  OP_TDB      = 6'h09;   // 001001 in bits 8..3
    localparam logic [5:0]  OP_TRAP     = 6'h0f;   // 001111 in bits 8..3
    localparam logic [2:0]  TRAP_ONE    = 3'h2;    // one operand word
    localparam logic [2:0]  TRAP_TWO    = 3'h3;    // two operand words
    localparam logic [2:0]  TRAP_NONE   = 3'h4;    // no operand word

    // response word layout: kind in the high byte, result in bit 0
    localparam logic [7:0]  RESP_NULL   = 8'h08;   // null primitive kind code
    localparam int          RESP_COND   = 0;       // true/false indicator bit

    localparam logic [15:0] CNT_EXPIRED = 16'hffff; // counter low half at minus one
    localparam logic [31:0] WORD_BYTES  = 32'h2;    // bytes per instruction word

    // register port indices
    localparam logic [3:0]  REG_STATUS  = 4'h8;    // sticky events, read only
    localparam logic [3:0]  REG_CLEAR   = 4'h9;    // write one to clear, write only
    localparam logic [3:0]  REG_ENABLE  = 4'ha;    // interrupt enables
    localparam logic [3:0]  REG_SCAN    = 4'hb;    // scan pointer, read only
    localparam logic [3:0]  REG_STATE   = 4'hc;    // state and last result, read only

    // event bit positions
    localparam int          EV_TRAP     = 0;       // trap taken
    localparam int          EV_ILLEGAL  = 1;       // invalid encoding
    localparam int          EV_EXPIRED  = 2;       // loop counter ran out
    localparam int          EV_BRANCH   = 3;       // loop branch taken
    localparam int          EV_W        = 4;       // number of events

    localparam logic [EV_W-1:0] ENABLE_RST = 4'h0; // enables after reset

    typedef enum logic [7:0] {
        S_IDLE    = 8'h01,  // waiting for an operation word
        S_GET_SEL = 8'h02,  // fetching the selector word
        S_WR_COND = 8'h04,  // writing the condition register
        S_RD_RESP = 8'h08,  // reading the response register
        S_SERVICE = 8'h10,  // serving a requested service
        S_EVAL    = 8'h20,  // acting on the condition result
        S_GET_DSP = 8'h40,  // fetching the displacement
        S_FINISH  = 8'h80   // instruction complete
    } state_t;

endpackage

// ---- src/cp_cond_seq.sv ----
// Purpose: main-processor sequencing of loop-branch and trap coprocessor ops
// Assumes: coprocessor, memory and service unit hold acks as pulses
// Notes:   data registers live here and are reachable over the register port
module cp_cond_seq
    import cp_cond_pkg::*;
#(
    parameter int EXT_WORDS = 0   // extension words defined by the coprocessor
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [15:0] op_word,
    input  wire logic [31:0] op_addr,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             cir_wr,
    output logic [15:0]      cir_wdata,
    output logic             cir_rd,
    input  wire logic        cir_ack,
    input  wire logic [15:0] cir_rdata,
    output logic             svc_req,
    output logic [15:0]      svc_word,
    input  wire logic        svc_done,
    output logic             busy,
    output logic             done,
    output logic             trap,
    output logic             illegal,
    output logic [31:0]      next_pc,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq
);

    import cp_cond_pkg::*;

    // sign-extend a 16-bit displacement to a long word
    function automatic logic [31:0] sext16(input logic [15:0] w);
        sext16 = {{16{w[15]}}, w};
    endfunction

    // operand words that a trap opmode carries
    function automatic logic [1:0] trap_words(input logic [2:0] m);
        case (m)
            TRAP_ONE: trap_words = 2'd1;
            TRAP_TWO: trap_words = 2'd2;
            default:  trap_words = 2'd0;
        endcase
    endfunction

    // opmode check for the trap form
    function automatic logic trap_mode_ok(input logic [2:0] m);
        trap_mode_ok = (m == TRAP_ONE) || (m == TRAP_TWO) || (m == TRAP_NONE);
    endfunction

    state_t             st_q;          // sequencer state
    state_t             st_d;          // next state
    logic [31:0]        scan_q;        // instruction scan pointer
    logic [31:0]        scan_d;
    logic [15:0]        op_q;          // latched operation word
    logic               is_tdb_q;      // loop-branch form latched
    logic               cond_q;        // last condition result
    logic               cond_d;
    logic [31:0]        dreg [8];      // main processor data registers
    logic [15:0]        wdata_q;       // selector word for the coprocessor
    logic [15:0]        svcw_q;        // pending service request word
    logic [31:0]        npc_q;         // address to continue at
    logic [31:0]        npc_d;
    logic [EV_W-1:0]    ev_d;          // events raised this cycle
    logic [EV_W-1:0]    sts_q;         // sticky status
    logic [EV_W-1:0]    sts_d;
    logic [EV_W-1:0]    en_q;          // interrupt enables
    logic [EV_W-1:0]    en_d;
    logic               irq_q;
    logic               busy_q;
    logic               done_q;
    logic               trap_q;
    logic               ill_q;
    logic               cir_wr_q;
    logic               cir_rd_q;
    logic               svc_q;
    logic [31:0]        rdata_q;
    logic               dec_we;        // counter decrement strobe
    logic [15:0]        dec_lo;        // decremented counter low half
    logic               fetch_go;      // ask for the next word
    logic               wvalid;        // fetched word present
    logic [15:0]        wfetched;      // fetched word

    // decode of the arriving operation word
    wire                is_fline  = (op_word[15:12] == FLINE_CODE);
    wire                dec_tdb   = is_fline && (op_word[8:3] == OP_TDB);
    wire                dec_trap  = is_fline && (op_word[8:3] == OP_TRAP);
    wire                trap_ok   = trap_mode_ok(op_word[2:0]);
    wire                op_good   = dec_tdb || (dec_trap && trap_ok);

    // loop counter picked by the low opcode bits
    wire [2:0]          cnt_idx   = op_q[2:0];
    wire [31:0]         cnt_val   = dreg[cnt_idx];

    // response decode
    wire                resp_null = (cir_rdata[15:8] == RESP_NULL);
    wire                resp_cond = cir_rdata[RESP_COND];

    // scan pointer moved past extension and operand words
    wire [31:0]         ext_skip  = 32'(EXT_WORDS * 2);
    wire [31:0]         opnd_skip = {29'h0, trap_words(op_q[2:0]), 1'b0};

    // register port decode
    wire                wr_dreg   = reg_wr && !reg_addr[3];
    wire                wr_clear  = reg_wr && (reg_addr == REG_CLEAR);
    wire                wr_enable = reg_wr && (reg_addr == REG_ENABLE);
    wire [EV_W-1:0]     clr_bits  = wr_clear ? reg_wdata[EV_W-1:0] : '0;

    assign fetch_go = ((st_q == S_GET_SEL) || (st_q == S_GET_DSP)) && !mem_req && !wvalid;

    // program word fetch
    word_fetch u_fetch (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .go           (fetch_go),
        .addr         (scan_q),
        .mem_ack      (mem_ack),
        .mem_rdata    (mem_rdata),
        .mem_req_q    (mem_req),
        .mem_addr_q   (mem_addr),
        .word_valid_q (wvalid),
        .word_q       (wfetched)
    );

    // next state and datapath decisions
    always_comb begin
        st_d   = st_q;
        scan_d = scan_q;
        cond_d = cond_q;
        npc_d  = npc_q;
        ev_d   = '0;
        dec_we = 1'b0;
        dec_lo = cnt_val[15:0] - 16'h1;
        unique case (st_q)
            S_IDLE: begin
                // take a new operation, selector word follows it
                if (start) begin
                    scan_d = op_addr + WORD_BYTES;
                    if (op_good) begin
                        st_d = S_GET_SEL;
                    end else begin
                        // bad encoding finishes at once
                        ev_d[EV_ILLEGAL] = 1'b1;
                        npc_d            = op_addr + WORD_BYTES;
                        st_d             = S_FINISH;
                    end
                end
            end
            S_GET_SEL: begin
                // selector word arrives, step past it
                if (wvalid) begin
                    scan_d = scan_q + WORD_BYTES;
                    st_d   = S_WR_COND;
                end
            end
            S_WR_COND: begin
                // write taken, extension words skipped by count
                if (cir_ack) begin
                    scan_d = scan_q + ext_skip;
                    st_d   = S_RD_RESP;
                end
            end
            S_RD_RESP: begin
                // null answer ends polling, anything else is a request
                if (cir_ack) begin
                    if (resp_null) begin
                        cond_d = resp_cond;
                        st_d   = S_EVAL;
                    end else begin
                        st_d = S_SERVICE;
                    end
                end
            end
            S_SERVICE: begin
                // after the service, poll again
                if (svc_done) begin
                    st_d = S_RD_RESP;
                end
            end
            S_EVAL: begin
                if (is_tdb_q) begin
                    if (cond_q) begin
                        // true: fall through, counter left alone
                        npc_d = scan_q + WORD_BYTES;
                        st_d  = S_FINISH;
                    end else begin
                        dec_we = 1'b1;
                        if (dec_lo == CNT_EXPIRED) begin
                            ev_d[EV_EXPIRED] = 1'b1;
                            npc_d            = scan_q + WORD_BYTES;
                            st_d             = S_FINISH;
                        end else begin
                            st_d = S_GET_DSP;
                        end
                    end
                end else begin
                    // operand words are stepped over, never read
                    npc_d = scan_q + opnd_skip;
                    scan_d = scan_q + opnd_skip;
                    ev_d[EV_TRAP] = cond_q;
                    st_d  = S_FINISH;
                end
            end
            S_GET_DSP: begin
                // scan pointer still addresses the displacement word
                if (wvalid) begin
                    npc_d = scan_q + sext16(wfetched);
                    ev_d[EV_BRANCH] = 1'b1;
                    st_d  = S_FINISH;
                end
            end
            S_FINISH: begin
                st_d = S_IDLE;
            end
        endcase
    end

    // sticky status: a new event wins over a clear in the same cycle
    assign sts_d = (sts_q & ~clr_bits) | ev_d;
    assign en_d  = wr_enable ? reg_wdata[EV_W-1:0] : en_q;

    // state, pointer and result registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= S_IDLE;
            scan_q <= 32'h0;
            cond_q <= 1'b0;
            npc_q  <= 32'h0;
        end else begin
            st_q   <= st_d;
            scan_q <= scan_d;
            cond_q <= cond_d;
            npc_q  <= npc_d;
        end
    end

    // operation latch and selector word capture
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            op_q     <= 16'h0;
            is_tdb_q <= 1'b0;
            wdata_q  <= 16'h0;
        end else begin
            if (st_q == S_IDLE && start) begin
                op_q     <= op_word;
                is_tdb_q <= dec_tdb;
            end
            if (st_q == S_GET_SEL && wvalid) begin
                wdata_q <= wfetched;
            end
        end
    end

    // service request word taken from a non-null answer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            svcw_q <= 16'h0;
        end else if (st_q == S_RD_RESP && cir_ack && !resp_null) begin
            svcw_q <= cir_rdata;
        end
    end

    // coprocessor and service strobes follow the next state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cir_wr_q <= 1'b0;
            cir_rd_q <= 1'b0;
            svc_q    <= 1'b0;
            busy_q   <= 1'b0;
        end else begin
            cir_wr_q <= (st_d == S_WR_COND);
            cir_rd_q <= (st_d == S_RD_RESP);
            svc_q    <= (st_d == S_SERVICE);
            busy_q   <= (st_d != S_IDLE);
        end
    end

    // completion pulses
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
            trap_q <= 1'b0;
            ill_q  <= 1'b0;
        end else begin
            done_q <= (st_d == S_FINISH);
            trap_q <= ev_d[EV_TRAP];
            ill_q  <= ev_d[EV_ILLEGAL];
        end
    end

    // data registers: decrement touches only the low half
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                dreg[i] <= 32'h0;
            end
        end else if (dec_we) begin
            dreg[cnt_idx] <= {cnt_val[31:16], dec_lo};
        end else if (wr_dreg) begin
            dreg[reg_addr[2:0]] <= reg_wdata;
        end
    end

    // status, enables and interrupt level
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sts_q <= '0;
            en_q  <= ENABLE_RST;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            en_q  <= en_d;
            irq_q <= |(sts_d & en_d);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0;
        end else if (!reg_rd) begin
            rdata_q <= 32'h0;
        end else if (!reg_addr[3]) begin
            rdata_q <= dreg[reg_addr[2:0]];
        end else begin
            unique case (reg_addr)
                REG_STATUS: rdata_q <= {28'h0, sts_q};
                REG_ENABLE: rdata_q <= {28'h0, en_q};
                REG_SCAN:   rdata_q <= scan_q;
                REG_STATE:  rdata_q <= {23'h0, cond_q, st_q};
                default:    rdata_q <= 32'h0;  // clear and unmapped read zero
            endcase
        end
    end

    assign cir_wr    = cir_wr_q;
    assign cir_wdata = wdata_q;
    assign cir_rd    = cir_rd_q;
    assign svc_req   = svc_q;
    assign svc_word  = svcw_q;
    assign busy      = busy_q;
    assign done      = done_q;
    assign trap      = trap_q;
    assign illegal   = ill_q;
    assign next_pc   = npc_q;
    assign reg_rdata = rdata_q;
    assign irq       = irq_q;

endmodule

// ---- src/word_fetch.sv ----
// Purpose: fetches one instruction word per request from program memory
// Assumes: memory holds the request until it answers with an ack
// Notes:   word_valid_q pulses one cycle with the fetched word
module word_fetch (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        go,
    input  wire logic [31:0] addr,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    output logic             mem_req_q,
    output logic [31:0]      mem_addr_q,
    output logic             word_valid_q,
    output logic [15:0]      word_q
);

    // request holds until acked, then the word is presented once
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mem_req_q    <= 1'b0;
            mem_addr_q   <= 32'h0;
            word_valid_q <= 1'b0;
            word_q       <= 16'h0;
        end else begin
            word_valid_q <= mem_req_q && mem_ack;
            if (mem_req_q && mem_ack) begin
                mem_req_q <= 1'b0;  // answer taken
                word_q    <= mem_rdata;
            end else if (go && !mem_req_q) begin
                mem_req_q  <= 1'b1; // new request
                mem_addr_q <= addr;
            end
        end
    end

endmodule

// ---- verif/cp_cond_checker.sv ----
// Purpose: port-level checks on the conditional sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every sequencer after the module
module cp_cond_checker
    import cp_cond_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [15:0] op_word,
    input  wire logic        mem_ack,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        cir_wr,
    input  wire logic [15:0] cir_wdata,
    input  wire logic        cir_rd,
    input  wire logic        cir_ack,
    input  wire logic [15:0] cir_rdata,
    input  wire logic        svc_req,
    input  wire logic        busy,
    input  wire logic        done,
    input  wire logic        trap,
    input  wire logic        illegal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        got_res_q;  // condition result seen
    logic [15:0] word_q;     // last word handed over by memory
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // last fetched word and whether a result arrived
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            got_res_q <= 1'b0;
            word_q    <= 16'h0;
        end else begin
            word_q <= mem_ack ? mem_rdata : word_q;
            if (start && !busy) begin
                got_res_q <= 1'b0;
            end else if (cir_rd && cir_ack && cir_rdata[15:8] == RESP_NULL) begin
                got_res_q <= 1'b1;
            end
        end
    end
    property p_done_after_result;
        done |-> got_res_q || illegal;
    endproperty
    a_done_after_result: assert property (p_done_after_result)
        else $error("done without result");
    property p_wdata_is_selector;
        $rose(cir_wr) |-> cir_wdata == word_q;
    endproperty
    a_wdata_is_selector: assert property (p_wdata_is_selector)
        else $error("bad selector word");
    property p_cond_write_held;
        cir_wr && !cir_ack |=> cir_wr && $stable(cir_wdata);
    endproperty
    a_cond_write_held: assert property (p_cond_write_held)
        else $error("write dropped early");
    property p_read_follows_write;
        cir_wr && cir_ack |-> ##[1:4] cir_rd;
    endproperty
    a_read_follows_write: assert property (p_read_follows_write)
        else $error("no response read");
    property p_service_request;
        cir_rd && cir_ack && cir_rdata[15:8] != RESP_NULL |-> ##[1:8] svc_req;
    endproperty
    a_service_request: assert property (p_service_request)
        else $error("no service");
    property p_trap_then_done;
        trap |-> done;
    endproperty
    a_trap_then_done: assert property (p_trap_then_done)
        else $error("trap without done");
    property p_illegal_then_done;
        illegal |-> done;
    endproperty
    a_illegal_then_done: assert property (p_illegal_then_done)
        else $error("illegal without done");
    property p_bad_top_nibble;
        start && !busy && op_word[15:12] != FLINE_CODE |-> ##[1:2] illegal;
    endproperty
    a_bad_top_nibble: assert property (p_bad_top_nibble)
        else $error("bad op not refused");
endmodule

bind cp_cond_seq cp_cond_checker chk_u (.*);

// ---- verif/cp_far_model.sv ----
// Purpose: memory, coprocessor and service unit seen by the sequencer
// Assumes: one request at a time, held until acknowledged
// Notes:   lag sets the answer delay; released data shows the inverse word
module cp_far_model
    import cp_cond_pkg::*;
#(
    parameter logic [31:0] SEL_ADDR = 32'h102  // address of the selector word
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic        cir_wr,
    input  wire logic        cir_rd,
    input  wire logic        svc_req,
    input  wire logic [15:0] sel_word,
    input  wire logic [15:0] disp_word,
    input  wire logic [1:0]  n_svc,
    input  wire logic        cond_true,
    input  wire logic [3:0]  lag,
    output logic             mem_ack,
    output logic [15:0]      mem_rdata,
    output logic             cir_ack,
    output logic [15:0]      cir_rdata,
    output logic             svc_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]  wait_q;  // cycles waited on the open request
    logic [1:0]  left_q;  // services still to request
    logic        ack_q;   // answer cycle
    logic [15:0] word;    // memory word at the address
    logic [15:0] resp;    // response word on offer
    wire         any_req = mem_req | cir_wr | cir_rd | svc_req;
    assign word      = (mem_addr == SEL_ADDR) ? sel_word : disp_word;
    assign resp      = (left_q != 2'h0) ? {8'h01, 6'h0, left_q} : {RESP_NULL, 7'h0, cond_true};
    assign mem_ack   = ack_q & mem_req;
    assign cir_ack   = ack_q & (cir_wr | cir_rd);
    assign svc_done  = ack_q & svc_req;
    assign mem_rdata = mem_ack ? word : ~word;  // no stale word outside the answer
    assign cir_rdata = cir_ack ? resp : ~resp;
    // answer delay and service count
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q <= 4'h0;
            ack_q  <= 1'b0;
            left_q <= 2'h0;
        end else begin
            ack_q  <= any_req & !ack_q & (wait_q == lag);
            wait_q <= (any_req & !ack_q & (wait_q != lag)) ? wait_q + 4'h1 : 4'h0;
            if (cir_wr && ack_q) begin
                left_q <= n_svc;
            end else if (cir_rd && ack_q && left_q != 2'h0) begin
                left_q <= left_q - 2'h1;
            end
        end
    end
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the conditional sequencer
// Assumes: one extension word, operation word at 100
// Notes:   reset checks first, then table rows, then register and interrupt cases
module tb;
    import cp_cond_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] op; logic cond; logic [1:0] nsvc; logic [31:0] d_in; logic [15:0] disp;
        logic [31:0] pc; logic trp; logic ill; logic [31:0] d_exp;
    } row_t;
    row_t        rows [10];  // one instruction each
    logic        core_clk, rstn, start, reg_wr, reg_rd, mem_req, mem_ack, cir_wr, cir_rd;
    logic        cir_ack, svc_req, svc_done, busy, done, trap, illegal, irq, cond_true;
    logic        saw_trap, saw_ill;
    logic [15:0] op_word, mem_rdata, cir_wdata, cir_rdata, svc_word, sel_word, disp_word;
    logic [31:0] op_addr, mem_addr, next_pc, reg_wdata, reg_rdata, rd;
    logic [3:0]  reg_addr, lag;
    logic [1:0]  n_svc;
    int          err_count, checks, n;
    cp_cond_seq #(.EXT_WORDS(1)) dut_u (.*);
    cp_far_model far_u (.*);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one-cycle write strobe on the register port
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {rstn, start, reg_wr, reg_rd, cond_true, n_svc, lag, reg_addr} = '0;
        {op_word, sel_word, disp_word, reg_wdata} = '0;
        op_addr   = 32'h100;
        rows[0] = '{16'hf24b, '0, '0, 32'h5, 16'hfff0, 32'hf6, '0, '0, 32'h4};
        rows[1] = '{16'hf24b, '0, 2'h1, 32'h12340000, 16'hfff0, 32'h108, '0, '0, 32'h1234ffff};
        rows[2] = '{16'hf24b, '1, 2'h2, 32'h7, 16'hfff0, 32'h108, '0, '0, 32'h7};
        rows[3] = '{16'hf248, '0, '0, 32'h1, 16'h0010, 32'h116, '0, '0, '0};
        rows[4] = '{16'hf27a, '1, '0, '0, '0, 32'h108, '1, '0, '0};
        rows[5] = '{16'hf27b, '0, 2'h1, '0, '0, 32'h10a, '0, '0, '0};
        rows[6] = '{16'hf27c, '1, '0, '0, '0, 32'h106, '1, '0, '0};
        rows[7] = '{16'hf279, '1, '0, '0, '0, 32'h102, '0, '1, '0};
        rows[8] = '{16'he24b, '0, '0, '0, '0, 32'h102, '0, '1, '0};
        rows[9] = '{16'hf20b, '0, '0, '0, '0, 32'h102, '0, '1, '0};
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        reg_read(4'h3, rd);
        chk("dreg reset", 32'h0, rd);
        reg_read(REG_ENABLE, rd);
        chk("enable reset", 32'h0, rd);
        chk("busy reset", 32'h0, {31'h0, busy});
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            reg_write({1'b0, rows[i].op[2:0]}, rows[i].d_in);
            @(posedge core_clk);
            sel_word  <= 16'h0005 + 16'(i);
            n_svc     <= rows[i].nsvc;
            cond_true <= rows[i].cond;
            disp_word <= rows[i].disp;
            lag       <= 4'(i % 4);
            op_word   <= rows[i].op;
            start     <= 1'b1;
            @(posedge core_clk);
            start <= 1'b0;
            {saw_trap, saw_ill} = 2'b0;
            // trap and illegal stand beside done, so sample before the break
            for (n = 0; n < 300; n++) begin
                #1 saw_trap |= trap;
                saw_ill |= illegal;
                if (done === 1'b1) break;
                @(posedge core_clk);
            end
            if (n == 300) begin
                err_count++;
                $display("timeout in row %0d", i);
                test_done();
            end
            chk("next_pc", rows[i].pc, next_pc);
            chk("trap", {31'h0, rows[i].trp}, {31'h0, saw_trap});
            chk("illegal", {31'h0, rows[i].ill}, {31'h0, saw_ill});
            reg_read({1'b0, rows[i].op[2:0]}, rd);
            chk("loop counter", rows[i].d_exp, rd);
            $display("test %0d done", i);
        end
        chk("svc_word", 32'h101, {16'h0, svc_word});
        reg_read(REG_SCAN, rd);
        chk("scan", 32'h102, rd);
        reg_read(REG_STATUS, rd);
        chk("status", 32'hf, rd);
        reg_write(REG_ENABLE, 32'h4);
        @(posedge core_clk);
        #1 chk("irq on", 32'h1, {31'h0, irq});
        reg_write(REG_CLEAR, 32'hf);
        @(posedge core_clk);
        #1 chk("irq off", 32'h0, {31'h0, irq});
        reg_write(REG_STATUS, 32'hf);
        reg_read(REG_STATUS, rd);
        chk("status ro", 32'h0, rd);
        reg_read(4'hf, rd);
        chk("unmapped read", 32'h0, rd);
        $display("test registers done");
        test_done();
    end
endmodule
